/* File: verilog/sgsel_top.sv */
/*
 * Setting group selector: keeps one of eight groups active from
 * request pins, a forced selection and a remote selection, with an
 * APB register file and a per-group parameter store.
 * Assumes an APB master on sys_clk and asynchronous request pins.
 */
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sgsel_params.svh"

module sgsel_top
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Group request pins
   input  wire logic        group_one_request,
   input  wire logic        group_two_request,
   input  wire logic        group_three_request,
   input  wire logic        group_four_request,
   input  wire logic        group_five_request,
   input  wire logic        group_six_request,
   input  wire logic        group_seven_request,
   input  wire logic        group_eight_request,
   // Selection status
   output var  logic [2:0]  active_group,
   output var  logic [7:0]  active_onehot
);

   //----------------------------------------------------------------
   // Declarations
   //----------------------------------------------------------------
   logic [7:0]                  req_pins;
   logic [7:0]                  req_sync;
   sgsel_pkg::sgsel_group_type  act_reg;
   sgsel_pkg::sgsel_group_type  act_next;
   sgsel_pkg::sgsel_group_type  used_reg;
   sgsel_pkg::sgsel_choice_type force_sel_reg;
   sgsel_pkg::sgsel_choice_type remote_reg;
   sgsel_pkg::sgsel_paddr_type  psel_addr_reg;
   logic                        forced_override_enable_reg;
   logic                        prev_force_reg;
   logic                        prev_any_reg;
   sgsel_pkg::sgsel_group_type  prev_top_reg;
   logic                        ncfg_reg;
   logic                        ffail_reg;
   logic                        lowp_reg;
   logic                        wr_acc;
   logic                        force_wr;
   logic                        remote_wr;
   logic                        used_wr;
   logic                        stat_wr;
   logic                        top_any;
   sgsel_pkg::sgsel_group_type  top_idx;
   logic                        top_new;
   logic                        ncfg_set;
   logic                        ffail_set;
   logic                        lowp_set;
   logic [7:0]                  load_mask;
   logic [31:0]                 mem_rdata;
   sgsel_pkg::sgsel_group_type  remote_grp;

   //----------------------------------------------------------------
   // Request synchronisers
   //----------------------------------------------------------------
   assign req_pins = {group_eight_request, group_seven_request, group_six_request,
                      group_five_request, group_four_request, group_three_request,
                      group_two_request, group_one_request};

   sgsel_sync u_sync
   (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .pin_in   (req_pins),
      .sync_out (req_sync)
   );

   //----------------------------------------------------------------
   // APB decode
   //----------------------------------------------------------------
   // Zero wait states: the store read register follows PARAM_SEL
   // before any access phase that could read it.
   assign pready   = 1'b1;
   assign pslverr  = 1'b0;
   assign wr_acc   = psel && penable && pwrite;
   assign force_wr  = wr_acc && (paddr == `SGSEL_OFS_FORCE_SEL);
   assign remote_wr = wr_acc && (paddr == `SGSEL_OFS_REMOTE);
   assign used_wr   = wr_acc && (paddr == `SGSEL_OFS_USED);
   assign stat_wr   = wr_acc && (paddr == `SGSEL_OFS_STATUS);

   always_comb
   begin
      case (paddr)
         `SGSEL_OFS_FORCE_EN:   prdata = {31'h0000_0000, forced_override_enable_reg};
         `SGSEL_OFS_FORCE_SEL:  prdata = {28'h000_0000, force_sel_reg};
         `SGSEL_OFS_USED:       prdata = {29'h0000_0000, used_reg};
         `SGSEL_OFS_REMOTE:     prdata = {28'h000_0000, remote_reg};
         `SGSEL_OFS_STATUS:     prdata = {21'h00_0000, lowp_reg, ffail_reg, ncfg_reg,
                                          5'h00, act_reg};
         `SGSEL_OFS_PARAM_SEL:  prdata = {27'h000_0000, psel_addr_reg};
         `SGSEL_OFS_PARAM_DATA: prdata = mem_rdata;
         default:               prdata = 32'h0000_0000;
      endcase
   end

   //----------------------------------------------------------------
   // Configuration registers
   //----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         forced_override_enable_reg <= `SGSEL_FORCE_RST;
      else if (wr_acc && (paddr == `SGSEL_OFS_FORCE_EN))
         forced_override_enable_reg <= pwdata[0];
   end

   // Out-of-range codes fold to no selection
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         force_sel_reg <= `SGSEL_CHOICE_NONE;
         remote_reg    <= `SGSEL_CHOICE_NONE;
      end
      else
      begin
         if (force_wr)
            force_sel_reg <= (pwdata[3:0] > 4'h8) ? `SGSEL_CHOICE_NONE : pwdata[3:0];
         if (remote_wr)
            remote_reg <= (pwdata[3:0] > 4'h8) ? `SGSEL_CHOICE_NONE : pwdata[3:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         used_reg <= `SGSEL_USED_RST;
      else if (used_wr)
         used_reg <= pwdata[2:0];
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         psel_addr_reg <= 5'h00;
      else if (wr_acc && (paddr == `SGSEL_OFS_PARAM_SEL))
         psel_addr_reg <= pwdata[4:0];
   end

   //----------------------------------------------------------------
   // Parameter store with default load on growth
   //----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_load
         assign load_mask[g] = used_wr && (3'(g) > used_reg) && (3'(g) <= pwdata[2:0]);
      end
   endgenerate

   sgsel_param_mem u_mem
   (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .wr_en     (wr_acc && (paddr == `SGSEL_OFS_PARAM_DATA)),
      .addr      (psel_addr_reg),
      .wr_data   (pwdata),
      .rd_data   (mem_rdata),
      .load_mask (load_mask)
   );

   //----------------------------------------------------------------
   // Priority evaluation
   //----------------------------------------------------------------
   // Lowest set bit wins, so group 8 never masks anything
   always_comb
   begin
      top_idx = 3'h0;
      top_any = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         if (req_sync[i])
         begin
            top_idx = 3'(i);
            top_any = 1'b1;
         end
      end
   end

   // A winner is applied only when it changes or forcing has just been released, so a held level does
   // not cancel a later remote choice of a higher group.
   assign top_new    = top_any && (!prev_any_reg || (top_idx != prev_top_reg)
                                   || prev_force_reg);
   assign remote_grp = 3'(pwdata[3:0] - 4'h1);

   always_comb
   begin
      act_next  = act_reg;
      ncfg_set  = 1'b0;
      ffail_set = 1'b0;
      lowp_set  = 1'b0;
      if (forced_override_enable_reg)
      begin
         // Inputs and remote requests have no effect while forced
         if (force_wr && (pwdata[3:0] != 4'h0) && (pwdata[3:0] <= 4'h8))
         begin
            if (3'(pwdata[3:0] - 4'h1) <= used_reg)
               act_next = 3'(pwdata[3:0] - 4'h1);
            else
               ncfg_set = 1'b1;
         end
      end
      else
      begin
         if (force_wr)
            ffail_set = 1'b1;
         if (top_new)
         begin
            if (top_idx <= used_reg)
               act_next = top_idx;
            else
               ncfg_set = 1'b1;
         end
         if (remote_wr && (pwdata[3:0] != 4'h0) && (pwdata[3:0] <= 4'h8))
         begin
            if (top_any && (top_idx < remote_grp))
               lowp_set = 1'b1;
            else if (remote_grp > used_reg)
               ncfg_set = 1'b1;
            else if (!top_new)
               act_next = remote_grp;
         end
      end
      // Shrinking the range drops back to group 1
      if (used_wr && (act_next > pwdata[2:0]))
         act_next = `SGSEL_ACTIVE_RST;
   end

   //----------------------------------------------------------------
   // Active group and history
   //----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         act_reg <= `SGSEL_ACTIVE_RST;
      else
         act_reg <= act_next;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         prev_force_reg <= 1'b0;
         prev_any_reg   <= 1'b0;
         prev_top_reg   <= 3'h0;
      end
      else
      begin
         prev_force_reg <= forced_override_enable_reg;
         prev_any_reg   <= top_any;
         prev_top_reg   <= top_idx;
      end
   end

   assign active_group = act_reg;

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         active_onehot <= 8'h01;
      else
         active_onehot <= 8'(8'h01 << act_next);
   end

   //----------------------------------------------------------------
   // Sticky failure flags, write one to clear, set wins
   //----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ncfg_reg  <= 1'b0;
         ffail_reg <= 1'b0;
         lowp_reg  <= 1'b0;
      end
      else
      begin
         ncfg_reg  <= ncfg_set  || (ncfg_reg  && !(stat_wr && pwdata[`SGSEL_STAT_NCFG_BIT]));
         ffail_reg <= ffail_set || (ffail_reg && !(stat_wr && pwdata[`SGSEL_STAT_FFAIL_BIT]));
         lowp_reg  <= lowp_set  || (lowp_reg  && !(stat_wr && pwdata[`SGSEL_STAT_LOWP_BIT]));
      end
   end

   //----------------------------------------------------------------
   // Assertions
   //----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   a_onehot_match: assert property (active_onehot == (8'h01 << active_group))
      else $error("active one-hot does not match index");
   a_force_taken: assert property ((forced_override_enable_reg && force_wr && pwdata[3:0] != 4'h0
                                    && pwdata[3:0] <= 4'h8 && 3'(pwdata[3:0] - 4'h1) <= used_reg)
                                   |=> (active_group == $past(3'(pwdata[3:0] - 4'h1))))
      else $error("forced group not applied");
   a_force_off_ign: assert property ((!forced_override_enable_reg && force_wr) |=> ffail_reg)
      else $error("forced change without enable not flagged");
   a_forced_hold: assert property ((forced_override_enable_reg && !force_wr && !used_wr)
                                   |=> $stable(active_group))
      else $error("active group moved while forced");
   a_release_take: assert property ($fell(forced_override_enable_reg) && top_any && top_idx <= used_reg
                                    |=> active_group == $past(top_idx))
      else $error("static level did not take over");
   a_level_prio: assert property ((!forced_override_enable_reg && top_new && top_idx <= used_reg
                                   && !used_wr) |=> active_group == $past(top_idx))
      else $error("highest level request not selected");
   a_pulse_hold: assert property ((!top_any && !force_wr && !remote_wr && !used_wr)
                                  |=> $stable(active_group))
      else $error("active group changed without request");
   a_remote_refuse: assert property ((!forced_override_enable_reg && remote_wr && top_any
                                      && pwdata[3:0] != 4'h0 && pwdata[3:0] <= 4'h8
                                      && top_idx < remote_grp) |=> lowp_reg)
      else $error("remote request not refused");
   a_ncfg_flag: assert property ((!forced_override_enable_reg && top_new && top_idx > used_reg)
                                 |=> ncfg_reg)
      else $error("unconfigured request not flagged");
   a_in_range: assert property (active_group <= used_reg || $past(used_wr))
      else $error("active group outside enabled range");

endmodule

`default_nettype wire

/* File: verilog/sgsel_params.svh */
/*
 * Constants of the setting group selector: register byte offsets,
 * field positions, reset values and parameter-store defaults.
 * Assumes it is included by bare name from the selector's design files.
 */
`ifndef SGSEL_PARAMS_SVH
`define SGSEL_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SGSEL_OFS_FORCE_EN    12'h000
`define SGSEL_OFS_FORCE_SEL   12'h004
`define SGSEL_OFS_USED        12'h008
`define SGSEL_OFS_REMOTE      12'h00C
`define SGSEL_OFS_STATUS      12'h010
`define SGSEL_OFS_PARAM_SEL   12'h014
`define SGSEL_OFS_PARAM_DATA  12'h018

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SGSEL_STAT_ACT_LSB    0
`define SGSEL_STAT_NCFG_BIT   8
`define SGSEL_STAT_FFAIL_BIT  9
`define SGSEL_STAT_LOWP_BIT   10

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SGSEL_GROUPS          8
`define SGSEL_WORDS           4
`define SGSEL_ACTIVE_RST      3'h0
`define SGSEL_USED_RST        3'h0
`define SGSEL_CHOICE_NONE     4'h0
`define SGSEL_FORCE_RST       1'b0
`define SGSEL_PARAM_DEFAULT   32'h0000_0000

`endif

/* File: verilog/sgsel_pkg.sv */
/*
 * Types shared by the setting group selector files.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package sgsel_pkg;
   // Group index, 0 stands for group 1
   typedef logic [2:0] sgsel_group_type;
   // Choice field: 0 is no selection, 1..8 name a group
   typedef logic [3:0] sgsel_choice_type;
   // Parameter store address: group then word
   typedef logic [4:0] sgsel_paddr_type;
endpackage

`default_nettype wire

/* File: verilog/sgsel_sync.sv */
/*
 * Two-flop synchroniser for the eight group request pins.
 * Assumes the pins are asynchronous to sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module sgsel_sync
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   // Pins and synchronised levels
   input  wire logic [7:0] pin_in,
   output var  logic [7:0] sync_out
);

   logic [7:0] meta_reg;

   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1)
      begin : g_bit
         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
            begin
               meta_reg[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else
            begin
               meta_reg[i] <= pin_in[i];
               sync_out[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

/* File: verilog/sgsel_param_mem.sv */
/*
 * Per-group parameter store, eight groups of four words.
 * Read data come from a register; a load mask restores defaults of
 * whole groups in one cycle and wins over a software write.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sgsel_params.svh"

module sgsel_param_mem
(
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  rstn,
   // Software port
   input  wire logic                  wr_en,
   input  wire sgsel_pkg::sgsel_paddr_type addr,
   input  wire logic [31:0]           wr_data,
   output var  logic [31:0]           rd_data,
   // Default load per group
   input  wire logic [7:0]            load_mask
);

   logic [31:0] mem_reg [0:31];

   genvar e;
   generate
      for (e = 0; e < 32; e = e + 1)
      begin : g_entry
         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
               mem_reg[e] <= `SGSEL_PARAM_DEFAULT;
            else if (load_mask[e / `SGSEL_WORDS])
               mem_reg[e] <= `SGSEL_PARAM_DEFAULT;
            else if (wr_en && (addr == 5'(e)))
               mem_reg[e] <= wr_data;
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         rd_data <= 32'h0000_0000;
      else
         rd_data <= mem_reg[addr];
   end

endmodule

`default_nettype wire

/* File: verif/sgsel_req_src.sv */
/*
 * Model of the request sources in front of the selector: digital
 * inputs and user logic that raise group requests as pulses or levels.
 * Assumes the bench calls its tasks just after a rising sys_clk edge.
 */
`timescale 1ns/1ns
`default_nettype none

module sgsel_req_src
(
   // Clock
   input  wire logic       sys_clk,
   // Request lines, bit 0 is group 1
   output var  logic [7:0] req
);
   initial req = 8'h00;

   // ----------------------------------------------------------------
   // Request shapes
   // ----------------------------------------------------------------
   // Pulse long enough to clear the two-flop synchroniser
   task automatic pulse(input logic [7:0] mask);
      @(posedge sys_clk);
      req <= req | mask;
      repeat (3) @(posedge sys_clk);
      req <= req & ~mask;
   endtask

   // Static levels replace the whole request vector
   task automatic level(input logic [7:0] mask);
      @(posedge sys_clk);
      req <= mask;
   endtask
endmodule

`default_nettype wire

/* File: verif/tb_top.sv */
/*
 * Self-checking bench of the setting group selector: APB tasks,
 * a request source model and a fixed sequence of scenarios.
 * Assumes the design files and sgsel_params.svh are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sgsel_params.svh"

module tb_top;
   logic        sys_clk = 1'b0;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic [7:0]  req;
   logic [2:0]  active_group;
   logic [7:0]  active_onehot;
   int          bad_count   = 0;
   int          comparisons = 0;

   always #2 sys_clk = ~sys_clk;

   sgsel_req_src src (.sys_clk(sys_clk), .req(req));

   sgsel_top uut
   (
      .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
      .group_one_request(req[0]), .group_two_request(req[1]), .group_three_request(req[2]),
      .group_four_request(req[3]), .group_five_request(req[4]), .group_six_request(req[5]),
      .group_seven_request(req[6]), .group_eight_request(req[7]),
      .active_group(active_group), .active_onehot(active_onehot)
   );

   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   // Leading edge keeps back-to-back calls from driving psel twice at once
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // No count of its own: a hang is ended by the watchdog
      do
      begin
         @(posedge sys_clk);
      end
      while (pready !== 1'b1);
      q = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] e);
      comparisons++;
      if (got !== e)
      begin
         bad_count++;
         $display("unexpected at %0t: read %h, want %h", $time, got, e);
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk_word(q, e);
   endtask

   // Settles past the synchroniser and evaluation edges before looking
   task automatic chk_grp(input logic [2:0] e);
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      comparisons++;
      if (active_group !== e || active_onehot !== (8'h01 << e))
      begin
         bad_count++;
         $display("unexpected at %0t: active %0d, want %0d", $time, active_group, e);
      end
   endtask

   task automatic conclude;
      $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      conclude();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      rstn    <= 1'b0;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= 12'h000;
      pwdata  <= 32'h0000_0000;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      chk_grp(3'h0);
      rd(`SGSEL_OFS_STATUS, 32'h0000_0000);
      rd(`SGSEL_OFS_FORCE_SEL, 32'h0000_0000);
      rd(`SGSEL_OFS_FORCE_EN, 32'h0000_0000);
      rd(`SGSEL_OFS_USED, 32'h0000_0000);
      rd(`SGSEL_OFS_REMOTE, 32'h0000_0000);
      // Group 3 word 0 dirtied, then dropped and re-enabled
      wr(`SGSEL_OFS_USED, 32'h0000_0007);
      wr(`SGSEL_OFS_PARAM_SEL, 32'h0000_0008);
      wr(`SGSEL_OFS_PARAM_DATA, 32'h0000_00A5);
      rd(`SGSEL_OFS_PARAM_DATA, 32'h0000_00A5);
      wr(`SGSEL_OFS_USED, 32'h0000_0000);
      wr(`SGSEL_OFS_USED, 32'h0000_0007);
      rd(`SGSEL_OFS_PARAM_DATA, 32'h0000_0000);
      src.pulse(8'h08);
      chk_grp(3'h3);
      chk_grp(3'h3);
      src.level(8'h02);
      chk_grp(3'h1);
      src.pulse(8'h04);
      chk_grp(3'h1);
      src.level(8'h01);
      chk_grp(3'h0);
      src.pulse(8'h02);
      chk_grp(3'h0);
      src.level(8'h10);
      chk_grp(3'h4);
      src.pulse(8'h60);
      chk_grp(3'h4);
      src.level(8'h14);
      chk_grp(3'h2);
      src.level(8'h80);
      chk_grp(3'h7);
      // Held group 8 under group 7: a lower level left behind a pulse would take over again
      src.level(8'hC0);
      chk_grp(3'h6);
      src.level(8'h00);
      src.level(8'h24);
      chk_grp(3'h2);
      // Remote path: refused under a higher level, then accepted
      src.level(8'h02);
      chk_grp(3'h1);
      wr(`SGSEL_OFS_REMOTE, 32'h0000_0005);
      chk_grp(3'h1);
      rd(`SGSEL_OFS_STATUS, 32'h0000_0401);
      wr(`SGSEL_OFS_STATUS, 32'h0000_0700);
      src.level(8'h00);
      wr(`SGSEL_OFS_REMOTE, 32'h0000_0006);
      chk_grp(3'h5);
      // Shrinking below the active group falls back to group 1
      wr(`SGSEL_OFS_USED, 32'h0000_0003);
      chk_grp(3'h0);
      wr(`SGSEL_OFS_REMOTE, 32'h0000_0007);
      chk_grp(3'h0);
      rd(`SGSEL_OFS_STATUS, 32'h0000_0100);
      wr(`SGSEL_OFS_STATUS, 32'h0000_0700);
      // Forced path
      wr(`SGSEL_OFS_FORCE_SEL, 32'h0000_0003);
      chk_grp(3'h0);
      rd(`SGSEL_OFS_STATUS, 32'h0000_0200);
      wr(`SGSEL_OFS_STATUS, 32'h0000_0700);
      wr(`SGSEL_OFS_FORCE_EN, 32'h0000_0001);
      wr(`SGSEL_OFS_FORCE_SEL, 32'h0000_0003);
      chk_grp(3'h2);
      wr(`SGSEL_OFS_FORCE_SEL, 32'h0000_0006);
      chk_grp(3'h2);
      rd(`SGSEL_OFS_STATUS, 32'h0000_0102);
      src.pulse(8'h01);
      chk_grp(3'h2);
      rd(`SGSEL_OFS_FORCE_EN, 32'h0000_0001);
      wr(`SGSEL_OFS_FORCE_EN, 32'h0000_0000);
      chk_grp(3'h2);
      wr(`SGSEL_OFS_FORCE_EN, 32'h0000_0001);
      src.level(8'h02);
      repeat (6) @(posedge sys_clk);
      wr(`SGSEL_OFS_FORCE_EN, 32'h0000_0000);
      chk_grp(3'h1);
      src.level(8'h00);
      conclude();
   end
endmodule

`default_nettype wire
